// File: rtl/dpwsb_regs.svh
`ifndef DPWSB_REGS_SVH
`define DPWSB_REGS_SVH
`define DPWSB_CLK_NS 50
`define DPWSB_T_EW_NS 12
`define DPWSB_T_WP_NS 12
`define DPWSB_T_WZ_NS 10
`define DPWSB_T_DW_NS 10
`define DPWSB_T_SWRD_NS 5
`define DPWSB_T_WH_NS 12
`define DPWSB_T_WDD_NS 30
`define DPWSB_CEIL_CYC(ns) (((ns) + `DPWSB_CLK_NS - 1) / `DPWSB_CLK_NS)
`define DPWSB_MIN1(c) (((c) < 1) ? 1 : (c))
`define DPWSB_WP_CYC `DPWSB_MIN1(`DPWSB_CEIL_CYC(`DPWSB_T_WP_NS))
`define DPWSB_WZDW_CYC `DPWSB_MIN1(`DPWSB_CEIL_CYC(`DPWSB_T_WZ_NS + `DPWSB_T_DW_NS))
`define DPWSB_SWRD_CYC `DPWSB_MIN1(`DPWSB_CEIL_CYC(`DPWSB_T_SWRD_NS))
`define DPWSB_WH_CYC `DPWSB_MIN1(`DPWSB_CEIL_CYC(`DPWSB_T_WH_NS))
`define DPWSB_WDD_CYC `DPWSB_MIN1(`DPWSB_CEIL_CYC(`DPWSB_T_WDD_NS))
`define DPWSB_ADDR_W 17
`define DPWSB_DATA_W 8
`define DPWSB_CNT_W 4
`define DPWSB_SYNC_W 3
`endif

// File: rtl/dpwsb_pkg.sv
package dpwsb_pkg;
  typedef enum logic [2:0] {
    DPWSB_IDLE = 3'h0,
    DPWSB_SETUP = 3'h1,
    DPWSB_PULSE = 3'h3,
    DPWSB_HOLD = 3'h2,
    DPWSB_READ = 3'h6,
    DPWSB_DONE = 3'h7
  } dpwsb_state_e;
  typedef struct packed {
    logic write;
    logic flag_area_select_n;
    logic [16:0] addr;
    logic [7:0] data;
  } dpwsb_req_s;
  typedef struct packed {
    logic ce_n;
    logic sem_n;
    logic rw_n;
    logic oe_n;
    logic [16:0] addr;
  } dpwsb_pins_s;
endpackage : dpwsb_pkg

// File: rtl/dpwsb_sync.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpwsb_regs.svh"
module dpwsb_sync (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [8:0] async,
  output logic [8:0] stable
);
  logic [8:0] st1;
  logic [8:0] st2;
  logic [8:0] st3;
  logic [8:0] next_stable;
  always_comb begin
    next_stable = stable;
    for (int i = 0; i < 9; i++) begin
      if (st2[i] == st3[i]) begin
        next_stable[i] = st2[i];
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st1 <= 9'h1FF;
      st2 <= 9'h1FF;
      st3 <= 9'h1FF;
      stable <= 9'h1FF;
    end else begin
      st1 <= async;
      st2 <= st1;
      st3 <= st2;
      stable <= next_stable;
    end
  end
endmodule : dpwsb_sync
`default_nettype wire

// File: rtl/dpwsb_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpwsb_regs.svh"
module dpwsb_host (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dpwsb_pkg::dpwsb_req_s req,
  input wire logic reqValid,
  input wire logic oeLowDuringWrite,
  output logic reqReady,
  output logic [7:0] rspData,
  output logic rspFlag,
  output logic rspValid,
  output dpwsb_pkg::dpwsb_pins_s pins,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic [7:0] dataIn,
  input wire logic busyIn_n
);
  // Timing counts in core clock cycles
  localparam logic [3:0] WP_CYC = 4'(`DPWSB_WP_CYC);
  localparam logic [3:0] WZDW_CYC = 4'(`DPWSB_WZDW_CYC);
  localparam logic [3:0] SWRD_CYC = 4'(`DPWSB_SWRD_CYC);
  localparam logic [3:0] WH_CYC = 4'(`DPWSB_WH_CYC);
  localparam logic [3:0] WDD_CYC = 4'(`DPWSB_WDD_CYC);
  // Read wait covers the access delay plus the input synchroniser
  localparam logic [3:0] RD_CYC = 4'(`DPWSB_WDD_CYC + `DPWSB_SYNC_W + 1);

  function automatic logic [3:0] maxCyc(input logic [3:0] a, input logic [3:0] b);
    maxCyc = (a > b) ? a : b;
  endfunction : maxCyc

  // Drop every select and both strobes, keep the address
  function automatic dpwsb_pkg::dpwsb_pins_s parkPins(input dpwsb_pkg::dpwsb_pins_s p);
    parkPins = p;
    parkPins.ce_n = 1'b1;
    parkPins.sem_n = 1'b1;
    parkPins.rw_n = 1'b1;
    parkPins.oe_n = 1'b1;
  endfunction : parkPins

  // Flag writes carry only bit zero, the rest stay low
  function automatic logic [7:0] wrData(input dpwsb_pkg::dpwsb_req_s r);
    wrData = r.flag_area_select_n ? {7'h00, r.data[0]} : r.data;
  endfunction : wrData

  // Busy and data pins are asynchronous to the core clock
  logic [8:0] syncOut;
  dpwsb_sync u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async({busyIn_n, dataIn}),
    .stable(syncOut)
  );

  logic busySeen_n;
  logic [7:0] dataSeen;
  assign busySeen_n = syncOut[8];
  assign dataSeen = syncOut[7:0];


  // Transfer sequencer state
  dpwsb_pkg::dpwsb_state_e state;
  dpwsb_pkg::dpwsb_state_e next_state;
  dpwsb_pkg::dpwsb_req_s cur;
  dpwsb_pkg::dpwsb_req_s next_cur;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic semWritten;
  logic next_semWritten;

  // Next values of the registered outputs
  dpwsb_pkg::dpwsb_pins_s next_pins;
  logic [7:0] next_dataOut;
  logic next_dataOe;
  logic next_reqReady;
  logic [7:0] next_rspData;
  logic next_rspFlag;
  logic next_rspValid;

  // Next-state and next-output decode
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_cnt = cnt;
    next_semWritten = semWritten;
    next_pins = pins;
    next_dataOut = dataOut;
    next_dataOe = dataOe;
    next_reqReady = 1'b0;
    next_rspData = rspData;
    next_rspFlag = rspFlag;
    next_rspValid = 1'b0;
    case (state)
      dpwsb_pkg::DPWSB_IDLE: begin
        // Wait for a request with all strobes parked
        next_pins = parkPins(pins);
        next_dataOe = 1'b0;
        if (semWritten) begin
          next_cnt = (cnt > 4'h0) ? cnt - 4'h1 : 4'h0;
          next_semWritten = (cnt > 4'h1);
        end else if (reqValid && !reqReady) begin
          next_reqReady = 1'b1;
          next_cur = req;
          next_pins.addr = req.addr;
          next_state = dpwsb_pkg::DPWSB_SETUP;
        end
      end
      dpwsb_pkg::DPWSB_SETUP: begin
        // Drive the select for the array or for the flags
        next_pins.ce_n = cur.flag_area_select_n;
        next_pins.sem_n = !cur.flag_area_select_n;
        if (cur.write) begin
          next_pins.rw_n = 1'b0;
          next_pins.oe_n = !oeLowDuringWrite;
          next_cnt = oeLowDuringWrite ? maxCyc(WP_CYC, WZDW_CYC) : WP_CYC;
          next_state = dpwsb_pkg::DPWSB_PULSE;
        end else begin
          next_pins.oe_n = 1'b0;
          next_cnt = RD_CYC;
          next_state = dpwsb_pkg::DPWSB_READ;
        end
      end
      dpwsb_pkg::DPWSB_PULSE: begin
        // Select falls with strobe, so the device keeps its drivers off
        next_dataOe = 1'b1;
        next_dataOut = wrData(cur);
        if (!busySeen_n && !cur.flag_area_select_n) begin
          next_cnt = WH_CYC;
        end else if (!dataOe) begin
          // First strobe cycle only turns the data drivers on
          next_cnt = cnt;
        end else if (cnt > 4'h1) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_pins = parkPins(pins);
          next_state = dpwsb_pkg::DPWSB_HOLD;
        end
      end
      dpwsb_pkg::DPWSB_HOLD: begin
        // Strobe is high again; data drops one cycle later
        next_dataOe = 1'b0;
        next_semWritten = cur.flag_area_select_n;
        next_cnt = cur.flag_area_select_n ? SWRD_CYC : 4'h0;
        next_rspValid = 1'b1;
        next_state = dpwsb_pkg::DPWSB_DONE;
      end
      dpwsb_pkg::DPWSB_READ: begin
        // Busy restarts the wait so data settles after its release
        if (!busySeen_n && !cur.flag_area_select_n) begin
          next_cnt = RD_CYC;
        end else if (cnt > 4'h1) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_rspData = dataSeen;
          next_rspFlag = dataSeen[0];
          next_rspValid = 1'b1;
          next_pins = parkPins(pins);
          next_semWritten = 1'b0;
          next_state = dpwsb_pkg::DPWSB_DONE;
        end
      end
      dpwsb_pkg::DPWSB_DONE: begin
        // One quiet cycle between transfers
        next_state = dpwsb_pkg::DPWSB_IDLE;
      end
      default: begin
        next_state = dpwsb_pkg::DPWSB_IDLE;
      end
    endcase
  end

  // Every output leaves through this register stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= dpwsb_pkg::DPWSB_IDLE;
      cur <= '0;
      cnt <= 4'h0;
      semWritten <= 1'b0;
      pins <= '{ce_n: 1'b1, sem_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, addr: 17'h0_0000};
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      reqReady <= 1'b0;
      rspData <= 8'h00;
      rspFlag <= 1'b0;
      rspValid <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      cnt <= next_cnt;
      semWritten <= next_semWritten;
      pins <= next_pins;
      dataOut <= next_dataOut;
      dataOe <= next_dataOe;
      reqReady <= next_reqReady;
      rspData <= next_rspData;
      rspFlag <= next_rspFlag;
      rspValid <= next_rspValid;
    end
  end
endmodule : dpwsb_host
`default_nettype wire

// File: verif/dpwsb_host_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dpwsb_host_chk (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire dpwsb_pkg::dpwsb_pins_s pins,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic busyIn_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_one_area: assert property (
    pins.ce_n || pins.sem_n) else $error("both areas selected");
  chk_addr_still: assert property (
    $changed(pins.addr) |-> pins.rw_n) else $error("address moved in write");
  chk_data_late: assert property (
    dataOe |-> !pins.rw_n || (pins.ce_n && pins.sem_n)) else $error("data drive clash");
  chk_data_setup: assert property (
    $fell(pins.rw_n) |=> dataOe && !pins.rw_n) else $error("pulse too short");
  chk_data_hold: assert property (
    $rose(pins.rw_n) |-> dataOe) else $error("data dropped early");
  chk_flag_bit: assert property (
    dataOe && !pins.sem_n |-> dataOut[7:1] == 7'h00) else $error("flag data bits");
  chk_flag_gap: assert property (
    $rose(pins.sem_n) |=> pins.sem_n) else $error("flag readback too soon");
  chk_busy_hold: assert property (
    !busyIn_n && !pins.rw_n && !pins.ce_n |=> !pins.rw_n) else $error("strobe ended in busy");
  chk_busy_tail: assert property (
    $rose(busyIn_n) && !pins.rw_n |=> !pins.rw_n) else $error("strobe ended at release");
  cover property (!pins.sem_n && !pins.rw_n);
  cover property (!pins.ce_n && !pins.rw_n);
  cover property (!busyIn_n && rspValid);
  cover property (!pins.oe_n && pins.rw_n && rspValid && !reqReady);
endmodule : dpwsb_host_chk
bind dpwsb_host dpwsb_host_chk u_chk (.core_clk, .arst_n, .reqReady, .rspValid, .pins,
  .dataOut, .dataOe, .busyIn_n);
`default_nettype wire

// File: verif/dpwsb_dev.sv
`timescale 1ns/1ns
`default_nettype none
module dpwsb_dev (
  input wire dpwsb_pkg::dpwsb_pins_s pins,
  input wire logic [7:0] dataOut,
  input wire logic busyN,
  output logic [7:0] dataIn
);
  logic [7:0] mem [int];
  logic [7:0] flag = 8'hFF;
  logic [7:0] rd;
  dpwsb_pkg::dpwsb_pins_s wrAt = '1;
  initial dataIn = 8'h00;
  always @(pins) begin
    if (!pins.rw_n) begin
      wrAt = pins;
    end else if (!wrAt.rw_n) begin
      if (!wrAt.ce_n && busyN) mem[wrAt.addr] = dataOut;
      // One host only, so a flag write never meets a rival
      if (!wrAt.sem_n) flag[wrAt.addr[2:0]] = dataOut[0];
      wrAt.rw_n = 1'b1;
    end
    if (!pins.sem_n) begin
      rd = {8{flag[pins.addr[2:0]]}};
    end else begin
      rd = mem.exists(pins.addr) ? mem[pins.addr] : 8'h00;
    end
    if (!pins.oe_n && pins.rw_n && !(pins.ce_n && pins.sem_n)) begin
      dataIn <= #20 rd;
    end else begin
      dataIn <= #20 ~rd;
    end
  end
endmodule : dpwsb_dev
`default_nettype wire

// File: verif/tb_dual_port_write_semaphore_busy.sv
`timescale 1ns/1ns
`default_nettype none
module tb_dual_port_write_semaphore_busy;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  dpwsb_pkg::dpwsb_req_s req = '0;
  logic reqValid = 1'b0;
  logic oeLowDuringWrite = 1'b0;
  logic busyIn_n = 1'b1;
  logic reqReady, rspFlag, rspValid, dataOe;
  logic [7:0] rspData, dataOut, dataIn;
  dpwsb_pkg::dpwsb_pins_s pins;
  logic [7:0] refMem [int];
  logic [31:0] seed = 32'h0001_06D6;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  always #25 core_clk = ~core_clk;
  dpwsb_host u_dut (.core_clk, .arst_n, .req, .reqValid, .oeLowDuringWrite, .reqReady,
    .rspData, .rspFlag, .rspValid, .pins, .dataOut, .dataOe, .dataIn, .busyIn_n);
  dpwsb_dev u_dev (.pins, .dataOut, .busyN(busyIn_n), .dataIn);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic op(input logic w, input logic s, input logic [16:0] a, input logic [7:0] d);
    req = '{w, s, a, d};
    reqValid = 1'b1;
    n = 0;
    while (!reqReady && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    reqValid = 1'b0;
    while (!rspValid && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 100) num_errors++;
    repeat (3) @(negedge core_clk);
  endtask : op
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(lfsr(seed));
      oeLowDuringWrite = seed[20];
      refMem[seed[16:0]] = seed[31:24];
      op(1'b1, 1'b0, seed[16:0], seed[31:24]);
      op(1'b0, 1'b0, seed[16:0], 8'h00);
      check("array read", rspData, refMem[seed[16:0]]);
    end
    for (int k = 0; k < 16; k++) begin
      op(1'b1, 1'b1, 17'(k / 2), {7'h00, k[0]});
      op(1'b0, 1'b1, 17'(k / 2), 8'h00);
      check("flag read", rspData, {8{k[0]}});
      check("flag bit", {7'h00, rspFlag}, {7'h00, k[0]});
    end
    // The bench plays the master arbiter: busy settles before the strobe falls
    busyIn_n = 1'b0;
    repeat (4) @(negedge core_clk);
    fork
      op(1'b1, 1'b0, 17'h0_0055, 8'hA5);
      begin
        repeat (8) @(negedge core_clk);
        busyIn_n = 1'b1;
      end
    join
    check("busy stall", 8'(n > 8), 8'h01);
    op(1'b0, 1'b0, 17'h0_0055, 8'h00);
    check("busy write", rspData, 8'hA5);
    print_verdict();
  end
endmodule : tb_dual_port_write_semaphore_busy
`default_nettype wire
